/* hmibl_top.sv */
`timescale 1ns/1ps
`include "hmibl_defines.svh"

module hmibl_top #(
   parameter int unsigned TICK10_CYC = `HMIBL_TICK_CYC
) (
   input  wire logic        clk_sys_in,
   input  wire logic        resetn_in,
   input  wire logic        button_in,
   input  wire logic        flow_above_cutoff_in,
   input  wire logic        severe_error_in,
   input  wire logic        config_error_in,
   input  wire logic        range_warn_in,
   input  wire logic [6:0]  confidence_pct_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic      [31:0] reg_rdata_out,
   output logic      [2:0]  backlight_rgb_out,
   output logic             home_active_out,
   output logic      [2:0]  home_view_out,
   output logic             identify_active_out
);

   hmibl_tick_if tk ();

   hmibl_ticker #(
      .TICK10_CYC (TICK10_CYC)
   ) u_ticker (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .tk         (tk)
   );

   // saturating clamp, shared by the two bounded registers
   function automatic logic [31:0] hmibl_clamp(input logic [31:0] v,
                                               input logic [31:0] lim);
      hmibl_clamp = (v > lim) ? lim : v;
   endfunction

   logic [31:0]           bl_delay;
   logic [31:0]           scr_delay;
   logic [2:0]            home_sel;
   logic [8:0]            id_cnt;
   logic [1:0]            policy;
   logic [31:0]           idle_sec;
   logic                  lit;
   hmibl_pkg::hmibl_scr_t scr;
   logic [2:0]            rot_view;
   logic [4:0]            rot_sec;

   logic [31:0]           next_bl_delay;
   logic [31:0]           next_scr_delay;
   logic [2:0]            next_home_sel;
   logic [8:0]            next_id_cnt;
   logic [1:0]            next_policy;
   logic [31:0]           next_idle_sec;
   logic                  next_lit;
   hmibl_pkg::hmibl_scr_t next_scr;
   logic [2:0]            next_rot_view;
   logic [4:0]            next_rot_sec;
   logic [31:0]           next_rdata;
   logic [2:0]            next_view;
   logic [2:0]            base_rgb;
   logic [2:0]            next_rgb;

   logic                  id_wr;
   logic                  bl_follow;
   logic                  bl_hold;
   logic [31:0]           bl_limit;

   assign id_wr      = reg_wr_in && (reg_addr_in == `HMIBL_OFS_IDENT);
   assign tk.restart = id_wr;

   // host register writes; identify count runs down on 10 ms ticks
   always_comb begin
      next_bl_delay  = bl_delay;
      next_scr_delay = scr_delay;
      next_home_sel  = home_sel;
      next_policy    = policy;
      next_id_cnt    = id_cnt;
      if (reg_wr_in) begin
         if (reg_addr_in == `HMIBL_OFS_BL_DELAY) begin
            next_bl_delay = reg_wdata_in;
         end else if (reg_addr_in == `HMIBL_OFS_SCR_DELAY) begin
            next_scr_delay = hmibl_clamp(reg_wdata_in, `HMIBL_SCR_MAX);
         end else if (reg_addr_in == `HMIBL_OFS_HOME_SEL) begin
            next_home_sel = reg_wdata_in[2:0];
         end else if (reg_addr_in == `HMIBL_OFS_POLICY) begin
            next_policy = reg_wdata_in[1:0];
         end
      end
      if (id_wr) begin
         next_id_cnt = 9'(hmibl_clamp(reg_wdata_in, `HMIBL_ID_MAX));
      end else if (tk.tick10 && id_cnt != 9'h0) begin
         next_id_cnt = id_cnt - 9'h1;
      end
   end

   // one-cycle read latency; unmapped addresses read zero
   always_comb begin
      next_rdata = reg_rdata_out;
      if (reg_rd_in) begin
         if (reg_addr_in == `HMIBL_OFS_BL_DELAY) begin
            next_rdata = bl_delay;
         end else if (reg_addr_in == `HMIBL_OFS_SCR_DELAY) begin
            next_rdata = scr_delay;
         end else if (reg_addr_in == `HMIBL_OFS_HOME_SEL) begin
            next_rdata = {29'h0, home_sel};
         end else if (reg_addr_in == `HMIBL_OFS_IDENT) begin
            next_rdata = {23'h0, id_cnt};
         end else if (reg_addr_in == `HMIBL_OFS_POLICY) begin
            next_rdata = {30'h0, policy};
         end else begin
            next_rdata = 32'h0;
         end
      end
   end

   // idle seconds, saturating so a long idle never wraps back to lit
   always_comb begin
      if (button_in) begin
         next_idle_sec = 32'h0;
      end else if (tk.tick1s && idle_sec != 32'hFFFFFFFF) begin
         next_idle_sec = idle_sec + 32'h1;
      end else begin
         next_idle_sec = idle_sec;
      end
   end

   // backlight on/off; other negative delays behave as always on
   assign bl_follow = (bl_delay == `HMIBL_BL_FOLLOW);
   assign bl_hold   = (bl_delay == 32'h0) || (bl_delay[31] && !bl_follow);
   assign bl_limit  = bl_follow ? `HMIBL_FLOW_HOLD_S : bl_delay;

   always_comb begin
      next_lit = lit;
      if (button_in) begin
         next_lit = 1'b1;
      end else if (bl_hold) begin
         next_lit = 1'b1;
      end else if (bl_follow && flow_above_cutoff_in) begin
         next_lit = 1'b1;
      end else if (idle_sec >= bl_limit) begin
         next_lit = 1'b0;
      end
   end

   // screen state and rotation through views 0..5
   always_comb begin
      next_scr      = scr;
      next_rot_view = rot_view;
      next_rot_sec  = rot_sec;
      case (scr)
         hmibl_pkg::SCR_USER: begin
            if (!button_in && scr_delay != 32'h0 &&
                idle_sec >= scr_delay) begin
               next_scr = hmibl_pkg::SCR_HOME;
            end
         end
         hmibl_pkg::SCR_HOME: begin
            if (button_in || scr_delay == 32'h0) begin
               next_scr = hmibl_pkg::SCR_USER;
            end
         end
         default: begin
            next_scr = hmibl_pkg::SCR_USER;
         end
      endcase
      if (scr != hmibl_pkg::SCR_HOME) begin
         next_rot_view = 3'h0;
         next_rot_sec  = 5'h0;
      end else if (tk.tick1s) begin
         if (rot_sec == `HMIBL_ROT_STEP_S - 5'h1) begin
            next_rot_sec  = 5'h0;
            next_rot_view = (rot_view == `HMIBL_VIEW_LAST_ROT) ?
                            3'h0 : rot_view + 3'h1;
         end else begin
            next_rot_sec = rot_sec + 5'h1;
         end
      end
      next_view = (home_sel == `HMIBL_VIEW_ROTATE) ? rot_view : home_sel;
   end

   // colour selection; fault colours show even after the idle timeout
   always_comb begin
      base_rgb = lit ? `HMIBL_RGB_WHITE : `HMIBL_RGB_OFF;
      if (policy == `HMIBL_POL_STATUS) begin
         if (severe_error_in) begin
            base_rgb = `HMIBL_RGB_RED;
         end else if (config_error_in) begin
            base_rgb = `HMIBL_RGB_BLUE;
         end else if (range_warn_in) begin
            base_rgb = `HMIBL_RGB_YELLOW;
         end
      end else if (policy == `HMIBL_POL_CONF) begin
         if (confidence_pct_in < `HMIBL_CONF_RED) begin
            base_rgb = `HMIBL_RGB_RED;
         end else if (confidence_pct_in < `HMIBL_CONF_VIOLET) begin
            base_rgb = `HMIBL_RGB_VIOLET;
         end else if (confidence_pct_in <= `HMIBL_CONF_YELLOW) begin
            base_rgb = `HMIBL_RGB_YELLOW;
         end
      end
      next_rgb = (id_cnt != 9'h0) ? ~base_rgb : base_rgb;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bl_delay            <= `HMIBL_RST_BL_DELAY;
         scr_delay           <= `HMIBL_RST_SCR_DELAY;
         home_sel            <= `HMIBL_RST_HOME_SEL;
         id_cnt              <= `HMIBL_RST_IDENT;
         policy              <= `HMIBL_RST_POLICY;
         idle_sec            <= 32'h0;
         lit                 <= 1'b1;
         scr                 <= hmibl_pkg::SCR_USER;
         rot_view            <= 3'h0;
         rot_sec             <= 5'h0;
         reg_rdata_out       <= 32'h0;
         backlight_rgb_out   <= `HMIBL_RGB_OFF;
         home_active_out     <= 1'b0;
         home_view_out       <= 3'h0;
         identify_active_out <= 1'b0;
      end else begin
         bl_delay            <= next_bl_delay;
         scr_delay           <= next_scr_delay;
         home_sel            <= next_home_sel;
         id_cnt              <= next_id_cnt;
         policy              <= next_policy;
         idle_sec            <= next_idle_sec;
         lit                 <= next_lit;
         scr                 <= next_scr;
         rot_view            <= next_rot_view;
         rot_sec             <= next_rot_sec;
         reg_rdata_out       <= next_rdata;
         backlight_rgb_out   <= next_rgb;
         home_active_out     <= (next_scr == hmibl_pkg::SCR_HOME);
         home_view_out       <= next_view;
         identify_active_out <= (next_id_cnt != 9'h0);
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   // any in-range non-zero count; zero and over-range identify writes do not exercise it
   sequence s_id_write;
      id_wr && reg_wdata_in != 32'h0 && reg_wdata_in <= `HMIBL_ID_MAX;
   endsequence

   sequence s_id_run;
      (id_cnt == $past(reg_wdata_in[8:0])) ##1 identify_active_out;
   endsequence

   chk_id_load_run: assert property (s_id_write |=> s_id_run)
      else $error("identify count not loaded");

   chk_id_clamp_max: assert property (
      id_wr && reg_wdata_in > `HMIBL_ID_MAX |=> id_cnt == 9'h1F4)
      else $error("identify count not clamped");

   chk_press_lights: assert property (
      button_in |=> lit && idle_sec == 0)
      else $error("press did not relight");

   chk_zero_on: assert property (bl_delay == 32'h0 |=> lit)
      else $error("zero delay let backlight go off");

   chk_flow_hold: assert property (
      bl_follow && flow_above_cutoff_in |=> lit)
      else $error("flow did not hold backlight");

   chk_off_cause: assert property (
      $fell(lit) |-> $past(idle_sec) >= $past(bl_limit) && !$past(button_in))
      else $error("backlight off too early");

   chk_home_never: assert property (
      scr_delay == 32'h0 |=> scr == hmibl_pkg::SCR_USER)
      else $error("home screen with return disabled");

   chk_home_cause: assert property (
      $rose(home_active_out) |-> $past(idle_sec) >= $past(scr_delay))
      else $error("home screen too early");

   chk_rot_step: assert property (
      $changed(rot_view) && scr == hmibl_pkg::SCR_HOME &&
      $past(scr) == hmibl_pkg::SCR_HOME |->
      $past(rot_sec) == 5'h13 && $past(tk.tick1s))
      else $error("rotation step not at 20 s");

   chk_view_fixed: assert property (
      home_sel != `HMIBL_VIEW_ROTATE && $stable(home_sel) |=>
      home_view_out == $past(home_sel))
      else $error("home view not the selection");

   chk_plain_white: assert property (
      policy == `HMIBL_POL_PLAIN |=>
      backlight_rgb_out == 3'h0 || backlight_rgb_out == 3'h7)
      else $error("status colour in plain policy");

   chk_conf_red: assert property (
      policy == `HMIBL_POL_CONF && confidence_pct_in < 7'h14 &&
      id_cnt == 9'h0 |=> backlight_rgb_out == `HMIBL_RGB_RED)
      else $error("low confidence not red");

   chk_severe_red: assert property (
      policy == `HMIBL_POL_STATUS && severe_error_in && id_cnt == 9'h0 |=>
      backlight_rgb_out == `HMIBL_RGB_RED)
      else $error("severe error not red");

   chk_reg_back: assert property (
      reg_wr_in && reg_addr_in == `HMIBL_OFS_BL_DELAY ##1
      reg_rd_in && reg_addr_in == `HMIBL_OFS_BL_DELAY && !reg_wr_in |=>
      reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("register readback mismatch");

endmodule // hmibl_top

/* hmibl_defines.svh */
`ifndef HMIBL_DEFINES_SVH
`define HMIBL_DEFINES_SVH

// timing
`define HMIBL_CLK_NS        4
`define HMIBL_TICK_NS       10000000
`define HMIBL_TICK_CYC      (`HMIBL_TICK_NS / `HMIBL_CLK_NS)
`define HMIBL_TICKS_PER_S   7'h64
`define HMIBL_FLOW_HOLD_S   32'h0000003C
`define HMIBL_ROT_STEP_S    5'h14

// register offsets
`define HMIBL_OFS_BL_DELAY  16'h6F16
`define HMIBL_OFS_SCR_DELAY 16'h6F18
`define HMIBL_OFS_HOME_SEL  16'h6F1A
`define HMIBL_OFS_IDENT     16'h6F1C
`define HMIBL_OFS_POLICY    16'h6F1E

// reset values
`define HMIBL_RST_BL_DELAY  32'h00000078
`define HMIBL_RST_SCR_DELAY 32'h00000078
`define HMIBL_RST_HOME_SEL  3'h0
`define HMIBL_RST_IDENT     9'h000
`define HMIBL_RST_POLICY    2'h0

// limits and codes
`define HMIBL_BL_FOLLOW     32'hFFFFFFFF
`define HMIBL_SCR_MAX       32'h00000258
`define HMIBL_ID_MAX        32'h000001F4
`define HMIBL_VIEW_ROTATE   3'h6
`define HMIBL_VIEW_LAST_ROT 3'h5
`define HMIBL_POL_STATUS    2'h0
`define HMIBL_POL_PLAIN     2'h1
`define HMIBL_POL_CONF      2'h2
`define HMIBL_CONF_RED      7'h14
`define HMIBL_CONF_VIOLET   7'h32
`define HMIBL_CONF_YELLOW   7'h46

// backlight colours {red, green, blue}
`define HMIBL_RGB_OFF       3'h0
`define HMIBL_RGB_WHITE     3'h7
`define HMIBL_RGB_RED       3'h4
`define HMIBL_RGB_BLUE      3'h1
`define HMIBL_RGB_YELLOW    3'h6
`define HMIBL_RGB_VIOLET    3'h5

`endif

/* hmibl_pkg.sv */
package hmibl_pkg;

   // screen state, one-hot
   typedef enum logic [1:0] {
      SCR_USER = 2'h1,
      SCR_HOME = 2'h2
   } hmibl_scr_t;

   typedef logic [2:0] hmibl_rgb_t;

endpackage

/* hmibl_tick_if.sv */
`timescale 1ns/1ps

interface hmibl_tick_if;
   logic restart;
   logic tick10;
   logic tick1s;

   modport gen (input restart, output tick10, output tick1s);
   modport use_ (output restart, input tick10, input tick1s);
endinterface

/* hmibl_ticker.sv */
`timescale 1ns/1ps
`include "hmibl_defines.svh"

module hmibl_ticker #(
   parameter int unsigned TICK10_CYC = `HMIBL_TICK_CYC
) (
   input  wire logic   clk_sys_in,
   input  wire logic   resetn_in,
   hmibl_tick_if.gen   tk
);

   logic [31:0] cyc;
   logic [6:0]  hund;
   logic        t10;
   logic        t1s;
   logic [31:0] next_cyc;
   logic [6:0]  next_hund;
   logic        next_t10;
   logic        next_t1s;

   // 10 ms prescaler, restart realigns it so identify spans are exact
   always_comb begin
      next_t10  = 1'b0;
      next_t1s  = 1'b0;
      next_hund = hund;
      if (tk.restart) begin
         next_cyc = 32'h0;
      end else if (cyc == 32'(TICK10_CYC - 1)) begin
         next_cyc = 32'h0;
         next_t10 = 1'b1;
         if (hund == `HMIBL_TICKS_PER_S - 7'h1) begin
            next_hund = 7'h0;
            next_t1s  = 1'b1;
         end else begin
            next_hund = hund + 7'h1;
         end
      end else begin
         next_cyc = cyc + 32'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cyc  <= 32'h0;
         hund <= 7'h0;
         t10  <= 1'b0;
         t1s  <= 1'b0;
      end else begin
         cyc  <= next_cyc;
         hund <= next_hund;
         t10  <= next_t10;
         t1s  <= next_t1s;
      end
   end

   assign tk.tick10 = t10;
   assign tk.tick1s = t1s;

endmodule // hmibl_ticker

/* hmibl_panel_model.sv */
`timescale 1ns/1ps

// operator panel: holds the button for a requested number of cycles
module hmibl_panel_model (
   input  wire logic        clk_sys_in,
   input  wire logic        press_in,
   input  wire logic [15:0] hold_in,
   output logic             button_out
);
   logic [15:0] left = 16'h0;

   // a request reloads the hold count, so long and short presses both work
   always @(posedge clk_sys_in) begin
      if (press_in)
         left <= hold_in;
      else if (left != 16'h0)
         left <= left - 16'h1;
   end

   assign button_out = (left != 16'h0);
endmodule // hmibl_panel_model

/* hmibl_top_test.sv */
`timescale 1ns/1ps

module hmibl_top_test;
   localparam int T10   = 4;     // 10 ms shrunk to 4 cycles, 1 s = 400
   localparam int S     = 100 * T10;
   localparam int LIMIT = 70000; // plan needs about 59600 cycles
   typedef struct packed {
      logic [2:0]  sel;
      logic [31:0] val;
   } hmibl_note_t;
   logic        clk_sys_in = 1'b0;
   logic        resetn_in  = 1'b0;
   logic        button, flow, sev, cfg, rng, wr_s, rd_s, push, probe;
   logic [6:0]  conf;
   logic [15:0] addr, hold;
   logic [31:0] wdata, rdata, got;
   logic [2:0]  rgb, view, rd_hist = 3'h0, flt [5], fexp [5];
   time         wr_end;
   logic        home, ident;
   hmibl_note_t notes [$];
   hmibl_note_t note;
   int          bad_count, checks_done, cyc, seed, v;

   hmibl_panel_model panel (
      .clk_sys_in (clk_sys_in),
      .press_in   (push),
      .hold_in    (hold),
      .button_out (button)
   );

   hmibl_top #(.TICK10_CYC(T10)) dut (
      .clk_sys_in           (clk_sys_in),
      .resetn_in            (resetn_in),
      .button_in            (button),
      .flow_above_cutoff_in (flow),
      .severe_error_in      (sev),
      .config_error_in      (cfg),
      .range_warn_in        (rng),
      .confidence_pct_in    (conf),
      .reg_addr_in          (addr),
      .reg_wr_in            (wr_s),
      .reg_rd_in            (rd_s),
      .reg_wdata_in         (wdata),
      .reg_rdata_out        (rdata),
      .backlight_rgb_out    (rgb),
      .home_active_out      (home),
      .home_view_out        (view),
      .identify_active_out  (ident)
   );

   always #2 clk_sys_in = ~clk_sys_in;

   task automatic conclude;
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         conclude();
      end
   end

   // read data is looked at two edges after the strobe, safe for 1 or 2
   always @(negedge clk_sys_in) begin
      rd_hist = {rd_hist[1:0], rd_s};
      if (rd_hist[2] || probe) begin
         note = notes.pop_front();
         case (note.sel)
            3'h0: got = rdata;
            3'h1: got = {29'h0, rgb};
            3'h2: got = {31'h0, home};
            3'h3: got = {29'h0, view};
            default: got = {31'h0, ident};
         endcase
         checks_done++;
         if (got !== note.val) begin
            bad_count++;
            $display("BAD %0t sel %0d got %h want %h", $time, note.sel,
                     got, note.val);
         end
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      if ($time == wr_end)
         step(1); // strobe drops for one edge between two writes
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      step(1);
      wr_s = 1'b0;
      wr_end = $time;
   endtask

   // a gap of two cycles keeps the next read off the pending answer
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      notes.push_back({3'h0, e});
      addr = a;
      rd_s = 1'b1;
      step(1);
      rd_s = 1'b0;
      step(2);
   endtask

   task automatic expect_out(input logic [2:0] s, input logic [31:0] e);
      notes.push_back({s, e});
      probe = 1'b1;
      step(1);
      probe = 1'b0;
      step(1);
   endtask

   task automatic press(input int n);
      hold = n[15:0];
      push = 1'b1;
      step(1);
      push = 1'b0;
      step(n + 3);
   endtask

   function automatic logic [31:0] conf_rgb(input logic [6:0] c);
      if (c < 7'h14)
         return 32'h4;
      if (c < 7'h32)
         return 32'h5;
      if (c <= 7'h46)
         return 32'h6;
      return 32'h7;
   endfunction

   // main sequence
   initial begin
      {flow, sev, cfg, rng, wr_s, rd_s, push, probe} = 8'h00;
      {conf, addr, hold, wdata} = 71'h0;
      seed = 26;
      flt  = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
      fexp = '{3'h4, 3'h1, 3'h6, 3'h7, 3'h4};
      step(3);
      resetn_in = 1'b1;
      rd_chk(16'h6F16, 32'h78);
      rd_chk(16'h6F18, 32'h78);
      rd_chk(16'h6F1A, 32'h0);
      wr(16'h6F20, 32'h5A);
      rd_chk(16'h6F20, 32'h0);
      v = $random(seed);
      wr(16'h6F16, v);
      rd_chk(16'h6F16, v);
      // plain policy, 3 s off delay, no return to home
      wr(16'h6F1E, 32'h1);
      wr(16'h6F16, 32'h3);
      wr(16'h6F18, 32'h0);
      press(5);
      expect_out(3'h1, 32'h7);
      step(2 * S - 14);
      expect_out(3'h1, 32'h7);
      step(S + 20);
      expect_out(3'h1, 32'h0);
      expect_out(3'h2, 32'h0);
      press(1);
      expect_out(3'h1, 32'h7);
      wr(16'h6F16, 32'h0);
      step(4 * S);
      expect_out(3'h1, 32'h7);
      // minus one: flow holds the light, else a fixed 60 s
      wr(16'h6F16, 32'hFFFFFFFF);
      flow = 1'b1;
      press(1);
      step(4 * S);
      expect_out(3'h1, 32'h7);
      flow = 1'b0;
      step(54 * S - 10);
      expect_out(3'h1, 32'h7);
      step(2 * S + 20);
      expect_out(3'h1, 32'h0);
      // home screen
      wr(16'h6F16, 32'h0);
      wr(16'h6F18, 32'h2BC);
      rd_chk(16'h6F18, 32'h258);
      wr(16'h6F18, 32'h2);
      for (int s = 0; s < 8; s++) begin
         wr(16'h6F1A, 32'(s));
         press(1);
         expect_out(3'h2, 32'h0);
         step(S - 16);
         expect_out(3'h2, 32'h0);
         step(S + 15);
         expect_out(3'h2, 32'h1);
         if (s != 6)
            expect_out(3'h3, 32'(s));
         else begin
            for (int k = 0; k < 3; k++) begin
               expect_out(3'h3, 32'(k));
               step(20 * S - 4);
            end
         end
      end
      // identify inverts the white light
      wr(16'h6F1C, 32'h5);
      expect_out(3'h4, 32'h1);
      expect_out(3'h1, 32'h0);
      step(4 * T10 + 8);
      expect_out(3'h4, 32'h0);
      expect_out(3'h1, 32'h7);
      wr(16'h6F1C, 32'h258);
      rd_chk(16'h6F1C, 32'h1F4);
      step(500 * T10 + 10);
      expect_out(3'h4, 32'h0);
      // status colours
      wr(16'h6F1E, 32'h0);
      for (int i = 0; i < 5; i++) begin
         {sev, cfg, rng} = flt[i];
         step(3);
         expect_out(3'h1, {29'h0, fexp[i]});
      end
      {sev, cfg, rng} = 3'h0;
      // confidence option taken as fitted before policy 2 is chosen
      wr(16'h6F1E, 32'h2);
      for (int i = 0; i < 20; i++) begin
         v = $random(seed);
         conf = (i < 8) ? 7'h13 + 7'(i % 2) + 7'h1E * 7'(i / 2)
                        : 7'((v & 32'h7FFFFFFF) % 101);
         step(3);
         expect_out(3'h1, conf_rgb(conf));
      end
      conclude();
   end
endmodule // hmibl_top_test
